// ==== core/bst_pkg.sv ====
package bst_pkg;
    // ------------------------------------------------------------
    // register widths
    // ------------------------------------------------------------
    localparam int IR_W = 8;
    localparam int ID_W = 32;
    localparam int BSR_W = 48;
    localparam int BCR_W = 3;
    // ------------------------------------------------------------
    // reset and capture values
    // ------------------------------------------------------------
    localparam logic [7:0] IR_RESET = 8'h81;
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [2:0] BCR_RESET = 3'h2;
    localparam int BSR_OE_HI = 47;
    localparam int BSR_OE_LO = 46;
    localparam logic [47:0] BSR_RESET = 48'hC000_0000_0000;
    // ------------------------------------------------------------
    // instruction codes and data-register selection
    // ------------------------------------------------------------
    localparam logic [7:0] OP_EXTEST = 8'h00;
    localparam logic [7:0] OP_IDCODE = 8'h81;
    localparam logic [7:0] OP_SAMPLE = 8'h82;
    localparam logic [7:0] OP_BCR = 8'h0E;
    localparam logic [7:0] OP_BYPASS = 8'hFF;
    // arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h1234_5679;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } bst_state_t;
    typedef enum logic [1:0] {
        DR_BYPASS, DR_ID, DR_BSR, DR_BCR
    } bst_dr_t;
endpackage

// ==== core/bst_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// two-flop synchroniser for the test pins
// ------------------------------------------------------------
module bst_sync #(
    parameter int W = 3,
    parameter logic [2:0] INIT = 3'h7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;

    // first flop feeds only the second
    always_comb begin
        meta_nxt = din;
        sync_nxt = meta_r;
    end

    // both stages start at the pulled-up level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT[W-1:0];
            dout <= INIT[W-1:0];
        end else begin
            meta_r <= meta_nxt;
            dout <= sync_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== core/bst_tap.sv ====
// Operation
// - state moves on rising test clock by mode select
// - sample on rising, outputs change on falling
// - sixteen states, six stable, ten transient
// - separate instruction and data scan paths
// - power-up lands in reset state
// - mode select high reaches reset within five
// - open mode select and data read high
// - reset loads instruction 10000001
// - reset sets output-enable cells 47 and 46
// - reset loads boundary control with 010
// - selected test runs only in idle
// - select states do nothing, always leave
// - capture-data loads selected data register
// - shift-data drives serial out from bit zero
// - instruction 8, bypass 1, identification 32 bits
// - boundary 48 cells, control 3 bits
// - serial in feeds, out drains shifted register
// - control derives only from clock, mode select
// - shift starts edge after entering shift state
// - serial out floats after entering first exit
// - update-data latches on following falling edge
// - new instruction takes effect on falling edge
`timescale 1ns/100ps
`default_nettype none
module bst_tap (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [bst_pkg::BSR_W-1:0] pinCapture,
    output logic tdoOut,
    output logic tdoOe_n,
    output logic testMode,
    output logic testRun,
    output logic [bst_pkg::BSR_W-1:0] bsrLatch,
    output logic [bst_pkg::BCR_W-1:0] bcrLatch,
    output logic [bst_pkg::IR_W-1:0] instruction,
    output logic [3:0] tapState
);
    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [2:0] pinSync;
    logic tckPrev_r;
    logic tckPrev_nxt;
    logic tckRise;
    logic tckFall;
    logic tmsS;
    logic tdiS;

    // open inputs sit high, so the synchroniser starts high
    bst_sync #(.W(3), .INIT(3'h7)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .din({tck, tms, tdi}),
        .dout(pinSync)
    );

    // edges of the sampled test clock
    always_comb begin
        tmsS = pinSync[1];
        tdiS = pinSync[0];
        tckPrev_nxt = pinSync[2];
        tckRise = pinSync[2] & ~tckPrev_r;
        tckFall = ~pinSync[2] & tckPrev_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tckPrev_r <= 1'b1;
        end else begin
            tckPrev_r <= tckPrev_nxt;
        end
    end

    // ------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------
    bst_pkg::bst_state_t state_r;
    bst_pkg::bst_state_t state_nxt;

    // next state from mode select only
    always_comb begin
        state_nxt = state_r;
        if (tckRise) begin
            case (state_r)
                bst_pkg::ST_RESET:
                    state_nxt = tmsS ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
                bst_pkg::ST_IDLE:
                    state_nxt = tmsS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                bst_pkg::ST_SEL_DR:
                    state_nxt = tmsS ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
                bst_pkg::ST_CAP_DR:
                    state_nxt = tmsS ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
                bst_pkg::ST_SH_DR:
                    state_nxt = tmsS ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
                bst_pkg::ST_EX1_DR:
                    state_nxt = tmsS ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
                bst_pkg::ST_PAU_DR:
                    state_nxt = tmsS ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
                bst_pkg::ST_EX2_DR:
                    state_nxt = tmsS ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
                bst_pkg::ST_UPD_DR:
                    state_nxt = tmsS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                bst_pkg::ST_SEL_IR:
                    state_nxt = tmsS ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
                bst_pkg::ST_CAP_IR:
                    state_nxt = tmsS ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
                bst_pkg::ST_SH_IR:
                    state_nxt = tmsS ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
                bst_pkg::ST_EX1_IR:
                    state_nxt = tmsS ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
                bst_pkg::ST_PAU_IR:
                    state_nxt = tmsS ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
                bst_pkg::ST_EX2_IR:
                    state_nxt = tmsS ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
                bst_pkg::ST_UPD_IR:
                    state_nxt = tmsS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                default:
                    state_nxt = bst_pkg::ST_RESET;
            endcase
        end
    end

    // power-up in reset state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= bst_pkg::ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // shift registers and shadow latches
    // ------------------------------------------------------------
    logic [bst_pkg::IR_W-1:0] irSh_r;
    logic [bst_pkg::IR_W-1:0] irSh_nxt;
    logic [bst_pkg::IR_W-1:0] ir_r;
    logic [bst_pkg::IR_W-1:0] ir_nxt;
    logic [bst_pkg::ID_W-1:0] idSh_r;
    logic [bst_pkg::ID_W-1:0] idSh_nxt;
    logic [bst_pkg::BSR_W-1:0] bsSh_r;
    logic [bst_pkg::BSR_W-1:0] bsSh_nxt;
    logic [bst_pkg::BSR_W-1:0] bsL_r;
    logic [bst_pkg::BSR_W-1:0] bsL_nxt;
    logic [bst_pkg::BCR_W-1:0] bcSh_r;
    logic [bst_pkg::BCR_W-1:0] bcSh_nxt;
    logic [bst_pkg::BCR_W-1:0] bcL_r;
    logic [bst_pkg::BCR_W-1:0] bcL_nxt;
    logic bypSh_r;
    logic bypSh_nxt;
    bst_pkg::bst_dr_t drSel;
    logic drBit;

    // instruction picks the data register
    always_comb begin
        case (ir_r)
            bst_pkg::OP_IDCODE: drSel = bst_pkg::DR_ID;
            bst_pkg::OP_EXTEST: drSel = bst_pkg::DR_BSR;
            bst_pkg::OP_SAMPLE: drSel = bst_pkg::DR_BSR;
            bst_pkg::OP_BCR: drSel = bst_pkg::DR_BCR;
            default: drSel = bst_pkg::DR_BYPASS;
        endcase
        case (drSel)
            bst_pkg::DR_ID: drBit = idSh_r[0];
            bst_pkg::DR_BSR: drBit = bsSh_r[0];
            bst_pkg::DR_BCR: drBit = bcSh_r[0];
            default: drBit = bypSh_r;
        endcase
    end

    // capture and shift on rising edges, update on falling edges
    always_comb begin
        irSh_nxt = irSh_r;
        idSh_nxt = idSh_r;
        bsSh_nxt = bsSh_r;
        bcSh_nxt = bcSh_r;
        bypSh_nxt = bypSh_r;
        ir_nxt = ir_r;
        bsL_nxt = bsL_r;
        bcL_nxt = bcL_r;
        if (tckRise) begin
            case (state_r)
                bst_pkg::ST_CAP_IR: irSh_nxt = bst_pkg::IR_CAPTURE;
                bst_pkg::ST_SH_IR:
                    irSh_nxt = {tdiS, irSh_r[bst_pkg::IR_W-1:1]};
                bst_pkg::ST_CAP_DR: begin
                    idSh_nxt = bst_pkg::ID_VALUE;
                    bypSh_nxt = 1'b0;
                    bcSh_nxt = bcL_r;
                    bsSh_nxt = pinCapture;
                end
                bst_pkg::ST_SH_DR: begin
                    case (drSel)
                        bst_pkg::DR_ID:
                            idSh_nxt = {tdiS, idSh_r[bst_pkg::ID_W-1:1]};
                        bst_pkg::DR_BSR:
                            bsSh_nxt = {tdiS, bsSh_r[bst_pkg::BSR_W-1:1]};
                        bst_pkg::DR_BCR:
                            bcSh_nxt = {tdiS, bcSh_r[bst_pkg::BCR_W-1:1]};
                        default: bypSh_nxt = tdiS;
                    endcase
                end
                default: begin
                end
            endcase
        end
        if (tckFall) begin
            case (state_r)
                bst_pkg::ST_RESET: begin
                    ir_nxt = bst_pkg::IR_RESET;
                    bsL_nxt[bst_pkg::BSR_OE_HI] = 1'b1;
                    bsL_nxt[bst_pkg::BSR_OE_LO] = 1'b1;
                    bcL_nxt = bst_pkg::BCR_RESET;
                end
                bst_pkg::ST_UPD_IR: ir_nxt = irSh_r;
                bst_pkg::ST_UPD_DR: begin
                    if (drSel == bst_pkg::DR_BSR) begin
                        bsL_nxt = bsSh_r;
                    end
                    if (drSel == bst_pkg::DR_BCR) begin
                        bcL_nxt = bcSh_r;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // reset values apply at power-up as well
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irSh_r <= bst_pkg::IR_RESET;
            ir_r <= bst_pkg::IR_RESET;
            idSh_r <= '0;
            bsSh_r <= '0;
            bsL_r <= bst_pkg::BSR_RESET;
            bcSh_r <= '0;
            bcL_r <= bst_pkg::BCR_RESET;
            bypSh_r <= 1'b0;
        end else begin
            irSh_r <= irSh_nxt;
            ir_r <= ir_nxt;
            idSh_r <= idSh_nxt;
            bsSh_r <= bsSh_nxt;
            bsL_r <= bsL_nxt;
            bcSh_r <= bcSh_nxt;
            bcL_r <= bcL_nxt;
            bypSh_r <= bypSh_nxt;
        end
    end

    // ------------------------------------------------------------
    // serial out and status outputs on falling edges, tapState on rising; testRun also clears at once in reset state
    // ------------------------------------------------------------
    logic tdoOut_nxt;
    logic tdoOe_n_nxt;
    logic testMode_nxt;
    logic testRun_nxt;

    always_comb begin
        tdoOut_nxt = tdoOut;
        tdoOe_n_nxt = tdoOe_n;
        testMode_nxt = testMode;
        testRun_nxt = testRun;
        if (tckFall) begin
            tdoOe_n_nxt = 1'b1;
            if (state_r == bst_pkg::ST_SH_IR) begin
                tdoOe_n_nxt = 1'b0;
                tdoOut_nxt = irSh_r[0];
            end else if (state_r == bst_pkg::ST_SH_DR) begin
                tdoOe_n_nxt = 1'b0;
                tdoOut_nxt = drBit;
            end
            testMode_nxt = (state_r != bst_pkg::ST_RESET) &&
                (ir_nxt == bst_pkg::OP_EXTEST);
            testRun_nxt = (state_r == bst_pkg::ST_IDLE) &&
                (ir_nxt == bst_pkg::OP_BCR);
        end
        if (state_r == bst_pkg::ST_RESET) begin
            testRun_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdoOut <= 1'b0;
            tdoOe_n <= 1'b1;
            testMode <= 1'b0;
            testRun <= 1'b0;
            bsrLatch <= bst_pkg::BSR_RESET;
            bcrLatch <= bst_pkg::BCR_RESET;
            instruction <= bst_pkg::IR_RESET;
            tapState <= bst_pkg::ST_RESET;
        end else begin
            tdoOut <= tdoOut_nxt;
            tdoOe_n <= tdoOe_n_nxt;
            testMode <= testMode_nxt;
            testRun <= testRun_nxt;
            bsrLatch <= bsL_nxt;
            bcrLatch <= bcL_nxt;
            instruction <= ir_nxt;
            tapState <= state_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/bst_tester.sv ====
`timescale 1ns/100ps
`default_nettype none
// board test controller driving the tap pins
module bst_tester (
    input wire logic clk,
    input wire logic tdoOut,
    input wire logic tdoOe_n,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // pins rest high, clock stands still between frames
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one tck period: fall, sample serial out, rise, hold
    task automatic step(input logic m, input logic di, output logic o,
        output logic oe_n);
        @(posedge clk);
        #1;
        tck = 1'b0;
        tms = m;
        tdi = di;
        repeat (16) @(posedge clk);
        #1;
        o = tdoOe_n ? ~tdoOut : tdoOut; // a floated line reads garbage
        oe_n = tdoOe_n;
        tck = 1'b1;
        repeat (16) @(posedge clk);
        #1 tdi = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== testbench/bst_tap_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// watches tap pins and outputs
module bst_tap_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [47:0] pinCapture,
    input wire logic tdoOut,
    input wire logic tdoOe_n,
    input wire logic testMode,
    input wire logic testRun,
    input wire logic [47:0] bsrLatch,
    input wire logic [2:0] bcrLatch,
    input wire logic [7:0] instruction,
    input wire logic [3:0] tapState
);
    logic inShift;
    // high in either shift state
    assign inShift = (tapState == 4'h4) || (tapState == 4'hB);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence tckRise; tck && !$past(tck); endsequence
    sequence tckFall; !tck && $past(tck); endsequence
    state_edge_a: assert property ($changed(tapState)
        |-> $past(tck, 3) && !$past(tck, 8)) else $error("state off rise");
    reset_fill_a: assert property (tckFall ##0 tapState == 4'h0
        |-> ##6 (instruction == 8'h81 && bcrLatch == 3'h2
        && bsrLatch[47:46] == 2'h3)) else $error("reset values wrong");
    out_drive_a: assert property (tckFall ##0 inShift
        |-> ##6 !tdoOe_n) else $error("serial out not driven");
    out_float_a: assert property (tckFall ##0 !inShift
        |-> ##6 tdoOe_n) else $error("serial out not floated");
    sel_dr_a: assert property (tckRise ##0 tapState == 4'h2
        |-> ##6 tapState == ($past(tms, 6) ? 4'h9 : 4'h3))
        else $error("data select exit wrong");
    sel_ir_a: assert property (tckRise ##0 tapState == 4'h9
        |-> ##6 tapState == ($past(tms, 6) ? 4'h0 : 4'hA))
        else $error("instruction select exit wrong");
    cap_dr_a: assert property (tckRise ##0 tapState == 4'h3
        |-> ##6 tapState == ($past(tms, 6) ? 4'h5 : 4'h4))
        else $error("capture exit wrong");
    run_idle_a: assert property (tckFall ##0 tapState != 4'h1
        |-> ##6 !testRun) else $error("test runs outside idle");
endmodule
bind bst_tap bst_tap_monitor bst_tap_monitor_inst (.clk(clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .pinCapture(pinCapture),
    .tdoOut(tdoOut), .tdoOe_n(tdoOe_n), .testMode(testMode),
    .testRun(testRun), .bsrLatch(bsrLatch), .bcrLatch(bcrLatch),
    .instruction(instruction), .tapState(tapState));
`default_nettype wire

// ==== testbench/tb_boundary_scan_tap_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin expQ.push_back(48'(e)); nmQ.push_back(nm); \
    gotQ.push_back(48'(g)); end
module tb_boundary_scan_tap_controller;
    logic clk = 1'b0;
    logic rst_n;
    logic tck, tms, tdi, tdoOut, tdoOe_n, testMode, testRun;
    logic [47:0] pinCapture, bsrLatch, d, r;
    logic [47:0] expQ[$];
    logic [47:0] gotQ[$];
    logic [2:0] bcrLatch;
    logic [7:0] instruction;
    logic [3:0] tapState;
    string nmQ[$];
    int errorCnt = 0;
    int nCompared = 0;
    int seed = 86472;
    // clock generator
    always #2.5 clk = ~clk;
    bst_tap bst_tap_inst (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .pinCapture(pinCapture), .tdoOut(tdoOut),
        .tdoOe_n(tdoOe_n), .testMode(testMode), .testRun(testRun),
        .bsrLatch(bsrLatch), .bcrLatch(bcrLatch),
        .instruction(instruction), .tapState(tapState));
    bst_tester bst_tester_inst (.clk(clk), .tdoOut(tdoOut),
        .tdoOe_n(tdoOe_n), .tck(tck), .tms(tms), .tdi(tdi));
    // compares each result with the oldest note
    always begin
        wait (gotQ.size() > 0);
        nCompared++;
        if (gotQ[0] !== expQ[0]) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", nmQ[0], expQ[0], gotQ[0]);
        end
        void'(gotQ.pop_front());
        void'(expQ.pop_front());
        void'(nmQ.pop_front());
    end
    task automatic closeOut;
        #1;
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic st(input logic m);
        logic o, e;
        bst_tester_inst.step(m, 1'b1, o, e);
    endtask
    // full scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [47:0] din,
        output logic [47:0] dout);
        logic o, e;
        dout = 48'h0;
        st(1'b1);
        if (ir) st(1'b1);
        st(1'b0);
        st(1'b0);
        for (int i = 0; i < n; i++) begin
            bst_tester_inst.step(i == n - 1, din[i], o, e);
            dout[i] = o;
            `CHK("tdoOe_n shift", 1'b0, e)
        end
        bst_tester_inst.step(1'b1, 1'b1, o, e);
        `CHK("tdoOe_n exit", 1'b1, e)
        st(1'b0);
    endtask
    // test sequence
    initial begin
        rst_n = 1'b0;
        pinCapture = 48'h0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        `CHK("tapState", 4'h0, tapState)
        `CHK("instruction", 8'h81, instruction)
        `CHK("bcrLatch", 3'h2, bcrLatch)
        `CHK("bsrLatch oe", 2'h3, bsrLatch[47:46])
        `CHK("tdoOe_n", 1'b1, tdoOe_n)
        `CHK("testMode", 1'b0, testMode)
        $display("reset test done");
        st(1'b0);
        scan(1'b1, 8, 48'hFF, d);
        `CHK("ir capture", 8'h81, d[7:0])
        `CHK("instruction", 8'hFF, instruction)
        r = 48'($random(seed));
        scan(1'b0, 8, r, d);
        `CHK("bypass out", {r[6:0], 1'b0}, d[7:0])
        $display("bypass test done");
        st(1'b1);
        st(1'b0);
        repeat (5) st(1'b1);
        `CHK("tapState", 4'h0, tapState)
        st(1'b1);
        `CHK("instruction", 8'h81, instruction)
        st(1'b0);
        scan(1'b0, 32, 48'h0, d);
        `CHK("id out", bst_pkg::ID_VALUE, d[31:0])
        $display("id test done");
        @(posedge clk);
        #1 pinCapture = 48'({$random(seed), $random(seed)});
        r = 48'({$random(seed), $random(seed)});
        scan(1'b1, 8, 48'(bst_pkg::OP_SAMPLE), d);
        scan(1'b0, 48, r, d);
        `CHK("bsr out", pinCapture, d)
        `CHK("bsrLatch", r, bsrLatch)
        $display("sample test done");
        scan(1'b1, 8, 48'(bst_pkg::OP_BCR), d);
        scan(1'b0, 3, 48'h5, d);
        `CHK("bcr capture", 3'h2, d[2:0])
        `CHK("bcrLatch", 3'h5, bcrLatch)
        st(1'b0);
        `CHK("testRun idle", 1'b1, testRun)
        st(1'b1);
        st(1'b1);
        `CHK("testRun select", 1'b0, testRun)
        st(1'b1);
        st(1'b0);
        scan(1'b1, 8, 48'(bst_pkg::OP_EXTEST), d);
        `CHK("testMode", 1'b1, testMode)
        repeat (6) st(1'b1);
        `CHK("testMode", 1'b0, testMode)
        `CHK("bcrLatch", 3'h2, bcrLatch)
        `CHK("bsrLatch oe", 2'h3, bsrLatch[47:46])
        $display("control test done");
        closeOut;
    end
    // watchdog
    initial begin
        #200000;
        errorCnt++;
        closeOut;
    end
endmodule
`default_nettype wire
